// [logic/otpma_top.sv]
// One-time-programmable memory access: read port, selective and full-array programming
`timescale 1ns/1ps
// What this block does
// - Unprogrammed bits read as zero
// - A programmed one never returns to zero until a reset clears the written map
// - Whole array programmable by one request, one byte burn after another
// - Selective byte cycles only set zero bits
// - Customer region holds 502 bytes
// - Reset clears the written map, so contents read as zero after reset
//
// Reads: rd_req is sampled on every edge and answered one cycle later.
// Reads are served while a burn runs; the byte being burnt reads old.
// Addresses past the customer region always read as zero.
// Selective program: prog_req with ready high and a legal address.
// Full program: prog_all walks every customer byte with one pattern.
// Each byte burn takes a fixed count of cycles, then one step cycle.
// Timing of one selective cycle, counted from the taking edge:
//   edge 0 takes the request and raises busy,
//   edges 1 to 4 count the burn time,
//   edge 5 writes the cell and enters the step state,
//   edge 6 drops busy and raises prog_done for one cycle.
// A full pass repeats burn and step for every customer byte.
// prog_done pulses for one cycle as busy falls and ready rises.
// A new request may arrive in the very cycle prog_done is high.
// Requests seen while busy are dropped, never queued; software
// must watch ready and resend.
// Limitation: the full pass uses one byte pattern for every address,
// so per-byte contents need selective cycles afterwards.
// The written map stands in for blank fuses; a real macro keeps its
// state across reset, so clearing it here only models a fresh part.
module otpma_top
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rd_req,
  input  wire logic [8:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  input  wire logic       prog_req,
  input  wire logic       prog_all,
  input  wire logic [8:0] prog_addr,
  input  wire logic [7:0] prog_data,
  output logic            busy,
  output logic            prog_done,
  output logic            ready
);

  // Fuse array; no reset value exists in silicon, so a valid map marks burnt bytes
  logic [7:0]  fuse_mem [0:otpma_pkg::OTPMA_BYTES-1];
  logic [otpma_pkg::OTPMA_BYTES-1:0] written_reg;
  logic [otpma_pkg::OTPMA_BYTES-1:0] written_next;

  otpma_pkg::otpma_state_t state_reg, state_next;
  logic [8:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic       all_reg, all_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       busy_next, done_next, ready_reg, ready_next;
  logic [7:0] rdat_next;
  logic       rval_next;
  logic       burn_we;
  logic [7:0] burn_val;

  // Address falls inside the customer region
  function automatic logic otpma_in_range(input logic [8:0] a);
    otpma_in_range = (a <= otpma_pkg::OTPMA_LAST);
  endfunction : otpma_in_range

  // Stored byte as seen by a reader: blank bytes report zero
  function automatic logic [7:0] otpma_peek(input logic [8:0] a, input logic [7:0] m,
                                            input logic w);
    otpma_peek = (w && a <= otpma_pkg::OTPMA_LAST) ? m : otpma_pkg::OTPMA_BLANK;
  endfunction : otpma_peek

  // Programming sequencer
  always_comb
  begin
    state_next = state_reg;
    addr_next  = addr_reg;
    data_next  = data_reg;
    all_next   = all_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    burn_we    = 1'b0;
    case (state_reg)
      otpma_pkg::OTPMA_IDLE:
      begin
        // Requests only honoured here, so a request during a burn is dropped
        // An out-of-range selective address is dropped silently
        if (prog_req && ready_reg && (prog_all || otpma_in_range(prog_addr)))
        begin
          state_next = otpma_pkg::OTPMA_BURN;
          addr_next  = prog_all ? otpma_pkg::OTPMA_ADDR_RST : prog_addr;
          data_next  = prog_data;
          all_next   = prog_all;
          cnt_next   = 4'h0;
        end
      end
      otpma_pkg::OTPMA_BURN:
      begin
        // Hold the cell write until the burn time has run out;
        // writing early would leave a weakly set fuse
        // The counter restarts for every byte of a full pass
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == otpma_pkg::OTPMA_BURN_LAST)
        begin
          burn_we    = 1'b1;
          state_next = otpma_pkg::OTPMA_STEP;
        end
      end
      otpma_pkg::OTPMA_STEP:
      begin
        // Full-array pass walks every customer byte with one pattern
        if (all_reg && addr_reg != otpma_pkg::OTPMA_LAST)
        begin
          addr_next  = addr_reg + 9'h001;
          cnt_next   = 4'h0;
          state_next = otpma_pkg::OTPMA_BURN;
        end
        else
        begin
          done_next  = 1'b1;
          state_next = otpma_pkg::OTPMA_IDLE;
        end
      end
      default:
        state_next = otpma_pkg::OTPMA_IDLE;
    endcase
  end

  // Status flags follow the next state so they change with it
  always_comb
  begin
    busy_next  = (state_next != otpma_pkg::OTPMA_IDLE);
    ready_next = (state_next == otpma_pkg::OTPMA_IDLE);
  end

  // Fuse only adds ones: OR with what is already there
  always_comb
  begin
    burn_val = data_reg | otpma_peek(addr_reg, fuse_mem[addr_reg], written_reg[addr_reg]);
  end

  // Read port, one cycle latency; open from reset release
  always_comb
  begin
    rval_next = rd_req;
    rdat_next = rd_req ? otpma_peek(rd_addr, fuse_mem[rd_addr], written_reg[rd_addr])
                       : otpma_pkg::OTPMA_BLANK;
  end

  // Sequencer registers; status outputs leave straight from these flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= otpma_pkg::OTPMA_IDLE;
      addr_reg  <= otpma_pkg::OTPMA_ADDR_RST;
      data_reg  <= otpma_pkg::OTPMA_BLANK;
      all_reg   <= 1'b0;
      cnt_reg   <= 4'h0;
      busy      <= 1'b0;
      prog_done <= 1'b0;
      ready_reg <= 1'b1;
      ready     <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      data_reg  <= data_next;
      all_reg   <= all_next;
      cnt_reg   <= cnt_next;
      busy      <= busy_next;
      prog_done <= done_next;
      ready_reg <= ready_next;
      ready     <= ready_next;
    end
  end

  // Read port registers; kept apart so reads never wait on the sequencer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data  <= otpma_pkg::OTPMA_BLANK;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data  <= rdat_next;
      rd_valid <= rval_next;
    end
  end

  // Written map next value: a burnt byte is marked and never unmarked
  always_comb
  begin
    written_next = written_reg;
    if (burn_we && otpma_in_range(addr_reg))
      written_next[addr_reg] = 1'b1;
  end

  // Written map is reset so the array starts blank; this models a fresh part, as a real fuse macro keeps its state
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      written_reg <= '0;
    else
      written_reg <= written_next;
  end

  // Array storage; no reset since a memory macro has none
  always_ff @(posedge clk)
  begin
    if (burn_we && otpma_in_range(addr_reg))
      fuse_mem[addr_reg] <= burn_val;
  end

endmodule : otpma_top

// [logic/otpma_pkg.sv]
// Package with sizes, burn timing and states for the one-time-programmable memory access block
package otpma_pkg;
  localparam int unsigned OTPMA_BYTES   = 502;
  localparam int unsigned OTPMA_AW      = 9;
  localparam logic [8:0]  OTPMA_LAST    = 9'h1f5;
  localparam logic [7:0]  OTPMA_BLANK   = 8'h00;
  localparam logic [8:0]  OTPMA_ADDR_RST = 9'h000;
  // Time to burn one byte into the fuse array
  localparam int unsigned OTPMA_BURN_NS     = 40;
  localparam int unsigned OTPMA_CLK_NS      = 8;
  localparam int unsigned OTPMA_BURN_CYCLES =
    (OTPMA_BURN_NS + OTPMA_CLK_NS - 1) / OTPMA_CLK_NS;
  localparam logic [3:0]  OTPMA_BURN_LAST   = 4'(OTPMA_BURN_CYCLES - 1);

  typedef enum logic [1:0]
  {
    OTPMA_IDLE  = 2'b00,
    OTPMA_BURN  = 2'b01,
    OTPMA_STEP  = 2'b11
  } otpma_state_t;
endpackage : otpma_pkg

// [sim/otpma_monitor.sv]
// Port checker for the one-time-programmable memory access block
`timescale 1ns/1ps
module otpma_monitor
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       rd_req,
  input wire logic [8:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       prog_req,
  input wire logic       prog_all,
  input wire logic [8:0] prog_addr,
  input wire logic       busy,
  input wire logic       prog_done,
  input wire logic       ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // A burn holds busy for its whole cell write time
  sequence s_burn; (busy && !ready) [*6]; endsequence
  property p_rd_ans; rd_req |=> rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_oob; rd_req && rd_addr > 9'h1f5 |=> rd_data == 8'h00; endproperty
  a_oob: assert property (p_oob) else $error("out of range read");
  property p_take;
    prog_req && ready && (prog_all || prog_addr <= 9'h1f5) |=> busy && !ready;
  endproperty
  a_take: assert property (p_take) else $error("program not taken");
  property p_len; $rose(busy) |-> s_burn; endproperty
  a_len: assert property (p_len) else $error("burn too short");
  property p_end; $fell(busy) |-> prog_done && ready; endproperty
  a_end: assert property (p_end) else $error("no done at end");
  property p_pulse; prog_done |=> !prog_done && !busy; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
endmodule : otpma_monitor
bind otpma_top otpma_monitor u_mon (.*);

// [sim/tb_otpma_top.sv]
// Self-checking bench for the one-time-programmable memory access block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("wrong value %0t %h", $time, a); end end
module tb_otpma_top;
  logic       clk = 1'b0, reset = 1'b1, rd_req = 1'b0, prog_req = 1'b0, prog_all = 1'b0;
  logic       rd_valid, busy, prog_done, ready;
  logic [8:0] rd_addr = 9'h000, prog_addr = 9'h000;
  logic [7:0] rd_data, prog_data = 8'h00;
  int         err_total = 0, checked = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  otpma_top dut (.*);
  task complete_run(input int lost);
    err_total += lost;
    $display("mismatches %0d of %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // One read; the answer stands for one cycle only, so look right after it lands
  task rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd_req, rd_addr} <= {1'b1, a};
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask : rd
  // Program; with h set the request is held into busy to show it is dropped
  task prog(input logic all, input logic [8:0] a, input logic [7:0] d, input logic h);
    int n;
    int exp;
    @(posedge clk);
    {prog_req, prog_all, prog_addr, prog_data} <= {1'b1, all, a, d};
    @(posedge clk);
    if (h)
    begin
      {prog_addr, prog_data} <= {a + 9'h001, 8'h02};
      @(posedge clk);
    end
    prog_req <= 1'b0;
    for (n = 0; prog_done !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
      if (n > 4000)
        complete_run(1);
    end
    exp = (otpma_pkg::OTPMA_BURN_CYCLES + 1) * (all ? otpma_pkg::OTPMA_BYTES : 1) - int'(h);
    `CHK(n, exp)
    `CHK({busy, ready}, 2'b01)
  endtask : prog
  // Main sequence; bits only ever gain ones
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(9'h005, 8'h00);
    prog(1'b0, 9'h005, 8'h0f, 1'b0);
    prog(1'b0, 9'h005, 8'hf0, 1'b0);
    rd(9'h005, 8'hff);
    prog(1'b0, 9'h005, 8'h00, 1'b0);
    rd(9'h005, 8'hff);
    prog(1'b0, 9'h007, 8'h01, 1'b1);
    rd(9'h007, 8'h01);
    rd(9'h008, 8'h00);
    prog(1'b0, 9'h1f5, 8'h5a, 1'b0);
    rd(9'h1f5, 8'h5a);
    rd(9'h1f6, 8'h00);
    prog(1'b1, 9'h000, 8'h21, 1'b0);
    rd(9'h000, 8'h21);
    rd(9'h005, 8'hff);
    rd(9'h1f5, 8'h7b);
    complete_run(0);
  end
endmodule : tb_otpma_top
